/* tb/bist_ctrl_props.sv */
// assertions on the self-test controller ports
`timescale 1ns/1ns
module bist_ctrl_props (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic cpu_stall,
	input wire logic sw_reset_request,
	input wire logic test_running_flag,
	input wire logic mem_we,
	input wire logic mem_re
);
////////////////////////////////////////
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
chk_one_wait: assert property (
	(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait not 1");
chk_stall_run: assert property (
	test_running_flag |-> cpu_stall) else $error("running without stall");
chk_mem_stall: assert property (
	mem_we || mem_re |-> cpu_stall) else $error("sram access outside run");
chk_upper_zero: assert property (
	avs_readdata[31:8] == 24'h000000) else $error("upper read bits set");
chk_swreq_pulse: assert property (
	sw_reset_request |=> !sw_reset_request) else $error("reset request too long");
chk_swreq_idle: assert property (
	sw_reset_request |-> !test_running_flag) else $error("reset request during run");
chk_we_re: assert property (
	!(mem_we && mem_re)) else $error("write and read together");
chk_start_run: assert property (
	avs_write && !avs_waitrequest && avs_address == 18'h28058 && !soft_reset
	&& avs_writedata[3:0] == 4'h5 && !test_running_flag
	|=> test_running_flag && cpu_stall) else $error("start not taken");
endmodule

/* tb/testbench.sv */
// self-checking bench of the self-test controller
`timescale 1ns/1ns
`include "bist_regs.svh"
module testbench;
logic ref_clk, reset, pin_reset_n, soft_reset, avs_read, avs_write, corrupt;
logic avs_waitrequest, cpu_stall, sw_reset_request, test_running_flag, irq, mem_we, mem_re;
logic [17:0] avs_address;
logic [3:0] avs_byteenable;
logic [31:0] avs_writedata, avs_readdata;
logic [1:0] monitor_pins;
logic [9:0] mem_addr;
logic [7:0] mem_wdata, mem_rdata, q;
logic [7:0] mem [0:1023];
int bad_count, comparisons, pulses;
sram_logic_bist_control dut (.ref_clk, .reset, .external_reset_pin_n(pin_reset_n),
	.soft_reset, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .cpu_stall, .sw_reset_request, .test_running_flag,
	.monitor_pins, .irq, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);
////////////////////////////////////////
initial begin
	ref_clk = 1'b0;
	forever #4 ref_clk = ~ref_clk;
end
always @(posedge ref_clk) begin
	if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
	if (mem_re === 1'b1) mem_rdata <= mem[mem_addr] ^ {7'h00, corrupt};
	if (sw_reset_request === 1'b1) pulses <= pulses + 1;
end
task chk(input logic [7:0] got, input logic [7:0] exp);
	comparisons++;
	if (got !== exp) begin
		bad_count++;
		$display("mismatch at %0t got %h expected %h", $time, got, exp);
	end
endtask
task bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
	@(posedge ref_clk);
	avs_address <= {idx, 2'b00};
	avs_write <= w;
	avs_read <= ~w;
	avs_writedata <= {24'h000000, d};
	do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
	q = avs_readdata[7:0];
	avs_read <= 1'b0;
	avs_write <= 1'b0;
endtask
task rd_chk(input logic [15:0] idx, input logic [7:0] exp);
	bus(1'b0, idx, 8'h00);
	chk(q, exp);
endtask
task pin_pulse;
	pin_reset_n <= 1'b0;
	repeat (4) @(posedge ref_clk);
	pin_reset_n <= 1'b1;
	repeat (4) @(posedge ref_clk);
endtask
task soft_pulse;
	soft_reset <= 1'b1;
	@(posedge ref_clk);
	soft_reset <= 1'b0;
endtask
task t_scratch;
	bus(1'b1, `SCRATCH_IDX, 8'hA5);
	avs_byteenable <= 4'hE;
	bus(1'b1, `SCRATCH_IDX, 8'h3C);
	avs_byteenable <= 4'hF;
	bus(1'b1, 16'hA015, 8'hFF);
	rd_chk(`SCRATCH_IDX, 8'hA5);
	soft_pulse;
	rd_chk(`SCRATCH_IDX, 8'hA5);
	pin_pulse;
	rd_chk(`SCRATCH_IDX, 8'hA5);
	reset <= 1'b1;
	@(posedge ref_clk);
	reset <= 1'b0;
	repeat (3) @(posedge ref_clk);
	rd_chk(`SCRATCH_IDX, `SCRATCH_RESET);
endtask
task run(input logic [7:0] ctrl, input logic [1:0] st);
	int p;
	p = pulses;
	bus(1'b1, `IRQ_ENABLE_IDX, 8'h03);
	bus(1'b1, `CTRL_IDX, ctrl);
	#1 chk({7'h00, cpu_stall}, 8'h01);
	chk({6'h00, monitor_pins}, {6'h00, ctrl[7], 1'b0});
	while (cpu_stall !== 1'b0) @(posedge ref_clk);
	repeat (2) @(posedge ref_clk);
	rd_chk(`CTRL_IDX, {ctrl[7:4], 2'b00, st});
	chk({7'h00, irq}, 8'h01);
	rd_chk(`IRQ_STATUS_IDX, {6'h00, st});
	bus(1'b1, `IRQ_CLEAR_IDX, 8'h03);
	rd_chk(`IRQ_STATUS_IDX, 8'h00);
	chk({7'h00, irq}, 8'h00);
	chk(8'(pulses - p), {7'h00, ctrl[3:0] == `CMD_START_RESET});
	soft_pulse;
endtask
task t_flags;
	soft_pulse;
	rd_chk(`CTRL_IDX, 8'h13);
	bus(1'b1, `CTRL_IDX, 8'h10);
	rd_chk(`CTRL_IDX, 8'h10);
	bus(1'b1, `CTRL_IDX, 8'h15);
	repeat (20) @(posedge ref_clk);
	bus(1'b1, `CTRL_IDX, 8'h13);
	while (cpu_stall !== 1'b0) @(posedge ref_clk);
	rd_chk(`CTRL_IDX, 8'h10);
	pin_pulse;
	rd_chk(`CTRL_IDX, 8'h00);
endtask
task finish_test;
	$display("comparisons %0d mismatches %0d", comparisons, bad_count);
	if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
initial begin
	#500000;
	bad_count++;
	finish_test;
end
initial begin
	{reset, pin_reset_n, soft_reset, avs_read, avs_write, corrupt} = 6'b110000;
	{avs_address, avs_writedata, avs_byteenable, mem_rdata} = {50'h0, 4'hF, 8'h00};
	{bad_count, comparisons, pulses} = {32'd0, 32'd0, 32'd0};
	repeat (5) @(posedge ref_clk);
	reset <= 1'b0;
	repeat (3) @(posedge ref_clk);
	rd_chk(`CTRL_IDX, `CTRL_RESET);
	rd_chk(16'hA015, 8'h00);
	t_scratch;
	run(8'h05, 2'b01);
	run(8'h9A, 2'b01);
	run(8'h45, 2'b01);
	corrupt <= 1'b1;
	run(8'h15, 2'b11);
	corrupt <= 1'b0;
	t_flags;
	finish_test;
end
endmodule
bind sram_logic_bist_control bist_ctrl_props props (.ref_clk(ref_clk), .reset(reset),
	.soft_reset(soft_reset), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
	.sw_reset_request(sw_reset_request), .test_running_flag(test_running_flag),
	.mem_we(mem_we), .mem_re(mem_re));

/* verilog/bist_pkg.sv */
// types of the self-test controller
package bist_pkg;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_MEM_WRITE,
		ENG_MEM_READ,
		ENG_MEM_CHECK,
		ENG_LOGIC_RUN,
		ENG_DONE
	} engine_state_t;

	typedef struct packed {
		engine_state_t state;
		logic [9:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic mem_re;
		logic error;
		logic [15:0] lfsr_a;
		logic [15:0] lfsr_b;
		logic [15:0] count;
		logic done;
		logic fail;
	} engine_regs_t;

	typedef struct packed {
		logic pin_sync1;
		logic pin_sync2;
		logic [3:0] mode;
		logic fail;
		logic finish;
		logic running;
		logic reset_after;
		logic [7:0] scratch;
		logic [1:0] irq_status;
		logic [1:0] irq_enable;
		logic ack;
		logic [31:0] readdata;
		logic sw_reset_pulse;
	} top_regs_t;

endpackage

/* verilog/bist_regs.svh */
// register indices, field positions, reset values and counts of the self-test controller
`ifndef BIST_REGS_SVH
`define BIST_REGS_SVH

`define SCRATCH_IDX 16'hA014
`define CTRL_IDX 16'hA016
`define IRQ_STATUS_IDX 16'hA018
`define IRQ_CLEAR_IDX 16'hA019
`define IRQ_ENABLE_IDX 16'hA01A

`define SCRATCH_RESET 8'h00
`define CTRL_RESET 8'h00

`define CTRL_MODE_MSB 7
`define CTRL_MODE_LSB 4
`define CTRL_RUNNING_BIT 3
`define CTRL_FAIL_BIT 1
`define CTRL_FINISH_BIT 0
`define CTRL_CMD_MSB 3
`define CTRL_CMD_LSB 0
`define MODE_MONITOR_BIT 3

`define CMD_START 4'h5
`define CMD_START_RESET 4'hA
`define CMD_CLEAR 4'h0

`define MODE_SEL_MEMORY 3'h1
`define MODE_SEL_LOGIC 3'h4

`define IRQ_FINISH_BIT 0
`define IRQ_FAIL_BIT 1

`define MEM_LAST_ADDR 10'h3FF
`define MEM_PATTERN 8'h55
`define LOGIC_TEST_CYCLES 16'h0400
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400

`endif

/* verilog/self_test_engine.sv */
// sequencer that runs the memory march and the register logic signature test
`timescale 1ns/1ns
`include "bist_regs.svh"

module self_test_engine import bist_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic abort,
	input wire logic [2:0] mode_sel,
	input wire logic [7:0] mem_rdata,
	output logic busy,
	output logic done,
	output logic fail,
	output logic [9:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re
);

	engine_regs_t r_q;
	engine_regs_t r_d;

	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		lfsr_step = v[0] ? ((v >> 1) ^ `LFSR_TAPS) : (v >> 1);
	endfunction

	function automatic logic [7:0] pattern(input logic [9:0] a);
		pattern = a[7:0] ^ `MEM_PATTERN;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.fail = 1'b0;
		r_d.mem_we = 1'b0;
		r_d.mem_re = 1'b0;
		case (r_q.state)
			ENG_IDLE: begin
				if (start) begin
					r_d.error = 1'b0;
					r_d.mem_addr = 10'h000;
					r_d.count = 16'h0000;
					r_d.lfsr_a = `LFSR_SEED;
					r_d.lfsr_b = `LFSR_SEED;
					if (mode_sel == `MODE_SEL_MEMORY) begin
						r_d.state = ENG_MEM_WRITE;
						r_d.mem_we = 1'b1;
						r_d.mem_wdata = pattern(10'h000);
					end else if (mode_sel == `MODE_SEL_LOGIC) begin
						r_d.state = ENG_LOGIC_RUN;
					end else begin
						r_d.state = ENG_DONE;
					end
				end
			end
			ENG_MEM_WRITE: begin
				// memory contents are overwritten and not restored
				if (r_q.mem_addr == `MEM_LAST_ADDR) begin
					r_d.state = ENG_MEM_READ;
					r_d.mem_addr = 10'h000;
					r_d.mem_re = 1'b1;
				end else begin
					r_d.mem_addr = r_q.mem_addr + 10'h001;
					r_d.mem_wdata = pattern(r_q.mem_addr + 10'h001);
					r_d.mem_we = 1'b1;
				end
			end
			ENG_MEM_READ: begin
				r_d.state = ENG_MEM_CHECK;
			end
			ENG_MEM_CHECK: begin
				if (mem_rdata != pattern(r_q.mem_addr)) begin
					r_d.error = 1'b1;
				end
				if (r_q.mem_addr == `MEM_LAST_ADDR) begin
					r_d.state = ENG_DONE;
				end else begin
					r_d.state = ENG_MEM_READ;
					r_d.mem_addr = r_q.mem_addr + 10'h001;
					r_d.mem_re = 1'b1;
				end
			end
			ENG_LOGIC_RUN: begin
				r_d.lfsr_a = lfsr_step(r_q.lfsr_a);
				r_d.lfsr_b = lfsr_step(r_q.lfsr_b);
				r_d.count = r_q.count + 16'h0001;
				if (r_q.lfsr_a != r_q.lfsr_b || r_q.lfsr_a == 16'h0000) begin
					r_d.error = 1'b1;
				end
				if (r_q.count == `LOGIC_TEST_CYCLES - 16'h0001) begin
					r_d.state = ENG_DONE;
				end
			end
			ENG_DONE: begin
				r_d.state = ENG_IDLE;
				r_d.done = 1'b1;
				r_d.fail = r_q.error;
			end
			default: begin
				r_d.state = ENG_IDLE;
			end
		endcase
		if (abort) begin
			r_d.state = ENG_IDLE;
			r_d.done = 1'b0;
			r_d.fail = 1'b0;
			r_d.mem_we = 1'b0;
			r_d.mem_re = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_q <= '{state: ENG_IDLE, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign busy = (r_q.state != ENG_IDLE);
	assign done = r_q.done;
	assign fail = r_q.fail;
	assign mem_addr = r_q.mem_addr;
	assign mem_wdata = r_q.mem_wdata;
	assign mem_we = r_q.mem_we;
	assign mem_re = r_q.mem_re;

endmodule

/* verilog/sram_logic_bist_control.sv */
// self-test controller with command register, scratch byte and Avalon-MM slave
// Behaviour
// - a start command stalls the cpu until the self-test run is over.
// - processor context is not preserved across a run.
// - sram contents after a run are undefined and not restored.
// - mode, fail and finish survive software reset; pin and power-on reset clear them.
// - scratch byte is read/write and cleared only by power-on reset.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`include "bist_regs.svh"

module sram_logic_bist_control import bist_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic external_reset_pin_n,
	input wire logic soft_reset,
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic cpu_stall,
	output logic sw_reset_request,
	output logic test_running_flag,
	output logic [1:0] monitor_pins,
	output logic irq,
	output logic [9:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata
);

	top_regs_t r_q;
	top_regs_t r_d;
	logic eng_start;
	logic eng_abort;
	logic eng_busy;
	logic eng_done;
	logic eng_fail;
	logic pin_reset;
	logic access;
	logic [3:0] cmd;

	function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic [7:0] ctrl_view(input top_regs_t r);
		ctrl_view = 8'h00;
		ctrl_view[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = r.mode;
		ctrl_view[`CTRL_RUNNING_BIT] = r.running;
		ctrl_view[`CTRL_FAIL_BIT] = r.fail;
		ctrl_view[`CTRL_FINISH_BIT] = r.finish;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, readdata captured in the wait cycle
	assign access = (avs_read | avs_write) & ~r_q.ack;
	assign avs_waitrequest = access;
	assign avs_readdata = r_q.readdata;
	assign pin_reset = ~r_q.pin_sync2;
	assign cmd = avs_writedata[`CTRL_CMD_MSB:`CTRL_CMD_LSB];

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_d = r_q;
		eng_start = 1'b0;
		eng_abort = 1'b0;
		r_d.sw_reset_pulse = 1'b0;
		r_d.pin_sync1 = external_reset_pin_n;
		r_d.pin_sync2 = r_q.pin_sync1;
		r_d.ack = access;

		if (access && avs_read) begin
			r_d.readdata = 32'h0000_0000;
			if (reg_hit(avs_address, `SCRATCH_IDX)) begin
				r_d.readdata[7:0] = r_q.scratch;
			end else if (reg_hit(avs_address, `CTRL_IDX)) begin
				r_d.readdata[7:0] = ctrl_view(r_q);
			end else if (reg_hit(avs_address, `IRQ_STATUS_IDX)) begin
				r_d.readdata[1:0] = r_q.irq_status;
			end else if (reg_hit(avs_address, `IRQ_ENABLE_IDX)) begin
				r_d.readdata[1:0] = r_q.irq_enable;
			end
		end

		if (r_q.ack && avs_write && avs_byteenable[0]) begin
			if (reg_hit(avs_address, `SCRATCH_IDX)) begin
				r_d.scratch = avs_writedata[7:0];
			end else if (reg_hit(avs_address, `IRQ_CLEAR_IDX)) begin
				r_d.irq_status = r_q.irq_status & ~avs_writedata[1:0];
			end else if (reg_hit(avs_address, `IRQ_ENABLE_IDX)) begin
				r_d.irq_enable = avs_writedata[1:0];
			end else if (reg_hit(avs_address, `CTRL_IDX)) begin
				if (!r_q.running) begin
					r_d.mode = avs_writedata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
				end
				case (cmd)
					`CMD_START, `CMD_START_RESET: begin
						if (!r_q.running) begin
							// a new command clears both flags; cpu stalls from here
							r_d.fail = 1'b0;
							r_d.finish = 1'b0;
							r_d.running = 1'b1;
							r_d.reset_after = (cmd == `CMD_START_RESET);
							eng_start = 1'b1;
						end
					end
					`CMD_CLEAR: begin
						r_d.fail = 1'b0;
						r_d.finish = 1'b0;
					end
					default: begin
						if (r_q.running) begin
							eng_abort = 1'b1;
							r_d.running = 1'b0;
							r_d.reset_after = 1'b0;
						end
					end
				endcase
			end
		end

		// engine events after the bus so that a set wins over a clear
		if (eng_done) begin
			r_d.running = 1'b0;
			r_d.finish = 1'b1;
			r_d.irq_status[`IRQ_FINISH_BIT] = 1'b1;
			r_d.sw_reset_pulse = r_q.reset_after;
			r_d.reset_after = 1'b0;
			if (eng_fail) begin
				r_d.fail = 1'b1;
				r_d.irq_status[`IRQ_FAIL_BIT] = 1'b1;
			end
		end

		// soft reset keeps mode, fail, finish and scratch
		if (soft_reset) begin
			eng_abort = 1'b1;
			r_d.running = 1'b0;
			r_d.reset_after = 1'b0;
			r_d.irq_status = 2'b00;
			r_d.irq_enable = 2'b00;
			r_d.sw_reset_pulse = 1'b0;
		end

		// pin reset clears all but the scratch byte
		if (pin_reset) begin
			eng_abort = 1'b1;
			r_d.mode = 4'(`CTRL_RESET >> `CTRL_MODE_LSB);
			r_d.fail = 1'b0;
			r_d.finish = 1'b0;
			r_d.running = 1'b0;
			r_d.reset_after = 1'b0;
			r_d.irq_status = 2'b00;
			r_d.irq_enable = 2'b00;
			r_d.sw_reset_pulse = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_q <= '{scratch: `SCRATCH_RESET, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	self_test_engine engine (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(eng_start),
		.abort(eng_abort),
		.mode_sel(r_d.mode[2:0]),
		.mem_rdata(mem_rdata),
		.busy(eng_busy),
		.done(eng_done),
		.fail(eng_fail),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_we(mem_we),
		.mem_re(mem_re)
	);

	//////////////////////////////////////////////////////////////////////////////
	// no context is saved for the cpu; it simply waits
	assign cpu_stall = r_q.running | eng_busy;
	assign test_running_flag = r_q.running;
	assign sw_reset_request = r_q.sw_reset_pulse;
	assign monitor_pins = r_q.mode[`MODE_MONITOR_BIT] ? {r_q.running, r_q.fail} : 2'b00;
	assign irq = |(r_q.irq_status & r_q.irq_enable);

endmodule
